// [hdl/e1_irq_pkg.sv]
package e1_irq_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_STATUS    = 16'h0B02;
    localparam logic [15:0] IDX_IRQ_EN    = 16'h0B03;
    localparam logic [15:0] IDX_FRAME_CTL = 16'h010B;
    localparam logic [15:0] ADDR_STATUS    = {IDX_STATUS[13:0], 2'b00};
    localparam logic [15:0] ADDR_IRQ_EN    = {IDX_IRQ_EN[13:0], 2'b00};
    localparam logic [15:0] ADDR_FRAME_CTL = {IDX_FRAME_CTL[13:0], 2'b00};

    // bit positions shared by status and enable registers
    localparam int BIT_REMOTE_STATE = 7;
    localparam int BIT_RESERVED     = 6;
    localparam int BIT_CAS_MF       = 5;
    localparam int BIT_KEEP_ZERO    = 4;
    localparam int BIT_LCV          = 3;
    localparam int BIT_OOF          = 2;
    localparam int BIT_AIS          = 1;
    localparam int BIT_YEL          = 0;

    // field of the framing control register
    localparam int FLEC_MSB = 2;

    // reset values and masks
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] IRQ_EN_RST     = 8'h00;
    localparam logic [2:0] FRAME_CTL_RST  = 3'h3;
    localparam logic [7:0] STAT_IMPL_MASK = 8'h2F;
    localparam logic [7:0] EN_WR_MASK     = 8'h3F;

    // consecutive non-FAS frames needed to change the remote alarm
    localparam int REMOTE_CONSEC = 2;

    // per-frame indications from the receive framing logic
    typedef struct packed {
        logic nfas_strobe;
        logic a_bit;
        logic fas_strobe;
        logic fas_err;
        logic lcv;
        logic ais;
        logic cas_mf_yel;
    } rx_events_t;

endpackage

// [hdl/remote_alarm_detect.sv]
module remote_alarm_detect #(
    parameter int CONSEC = 2
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // non-FAS frame sample
    input  wire logic strobe_in,
    input  wire logic a_bit_in,
    // alarm state
    output logic      alarm_out
);
    localparam int CW = $clog2(CONSEC + 1);
    localparam logic [CW-1:0] LAST = CW'(CONSEC - 1);

    logic [CW-1:0] cnt_q;
    logic          alarm_q;
    wire           differ  = strobe_in && (a_bit_in != alarm_q);
    wire           flip    = differ && (cnt_q == LAST);

    if (CONSEC < 1) begin : g_bad_consec
        $error("CONSEC must be at least 1");
    end

    // a sample equal to the present state breaks the run
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_q   <= '0;
            alarm_q <= 1'b0;
        end else if (flip) begin
            cnt_q   <= '0;
            alarm_q <= a_bit_in;
        end else if (differ) begin
            cnt_q   <= cnt_q + CW'(1);
        end else if (strobe_in) begin
            cnt_q   <= '0;
        end
    end

    assign alarm_out = alarm_q;

    AST_ALARM_SET: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(alarm_q) |-> $past(strobe_in && a_bit_in && cnt_q == LAST))
        else $error("remote alarm declared without enough ones");
    AST_ALARM_CLR: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $fell(alarm_q) |-> $past(strobe_in && !a_bit_in && cnt_q == LAST))
        else $error("remote alarm cleared without enough zeros");
endmodule

// [hdl/e1_alarm_error_irq_enable.sv]
// Operation
// - remote alarm declared after A bit one in two consecutive non-FAS frames
// - remote alarm cleared after A bit zero in two consecutive non-FAS frames
// - enable register bit 7 reads current remote alarm; writes ignored
// - bit 5 enables CAS multiframe yellow change interrupt, resets to zero
// - CAS multiframe yellow change fires on both declare and clear
// - bit 3 enables line code violation interrupt, resets to zero
// - each detected line code violation raises the interrupt when enabled
// - bit 2 enables out-of-frame change interrupt, resets to zero
// - out-of-frame change fires on both declare and clear
// - status bits set on event, cleared when software reads status
// - out-of-frame declared after programmed count of consecutive errored FAS
// - bit 1 enables AIS change interrupt on declare or clear
// - bit 0 enables remote alarm change interrupt on declare or clear
//
// Design decision made here: the APB interface to the registers.
module e1_alarm_error_irq_enable
    import e1_irq_pkg::*;
#(
    parameter int CONSEC = e1_irq_pkg::REMOTE_CONSEC
) (
    // clock and reset
    input  wire logic                   CLK_IN,
    input  wire logic                   RSTN_IN,
    // apb slave
    input  wire logic                   PSEL_IN,
    input  wire logic                   PENABLE_IN,
    input  wire logic                   PWRITE_IN,
    input  wire logic [15:0]            PADDR_IN,
    input  wire logic [31:0]            PWDATA_IN,
    output logic      [31:0]            PRDATA_OUT,
    output logic                        PREADY_OUT,
    output logic                        PSLVERR_OUT,
    // receive framer indications
    input  wire e1_irq_pkg::rx_events_t RX_EVENTS_IN,
    // alarm states and interrupt
    output logic                        REMOTE_ALARM_OUT,
    output logic                        OOF_STATE_OUT,
    output logic                        IRQ_OUT
);
    import e1_irq_pkg::*;

    if (CONSEC < 1 || CONSEC > 8) begin : g_bad_consec
        $error("CONSEC must lie in 1 to 8");
    end

    // bus state
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        slverr_q;

    // register state
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  en_q;
    logic [2:0]  fctl_q;

    // alarm tracking
    logic        rem_alarm;
    logic        rem_prev_q;
    logic        ais_prev_q;
    logic        cas_prev_q;
    logic        oof_q;
    logic        oof_prev_q;
    logic [2:0]  err_cnt_q;
    logic        irq_q;

    // address decode
    wire         hit_stat  = (PADDR_IN == ADDR_STATUS);
    wire         hit_en    = (PADDR_IN == ADDR_IRQ_EN);
    wire         hit_fctl  = (PADDR_IN == ADDR_FRAME_CTL);
    wire         hit_any   = hit_stat || hit_en || hit_fctl;

    // the ready flop adds one wait state so that read data is registered
    // an unmapped access still completes, flagged by slverr
    wire         access    = PSEL_IN && PENABLE_IN;
    wire         pready_d  = access && !pready_q;
    wire         done      = access && pready_q;
    wire         wr_done   = done && PWRITE_IN && !slverr_q;
    wire         rd_done   = done && !PWRITE_IN && !slverr_q;

    wire         wr_en     = wr_done && hit_en;
    wire         wr_fctl   = wr_done && hit_fctl;
    wire         wr_stat   = wr_done && hit_stat;
    wire         rd_stat   = rd_done && hit_stat;

    // read mux
    // bit 7 is the live alarm state, not a stored bit
    wire [7:0]   en_rd     = {rem_alarm, 1'b0, en_q[BIT_CAS_MF:0]};
    wire [7:0]   fctl_rd   = {5'h00, fctl_q};
    wire [7:0]   rd_byte   = hit_stat ? status_q :
                             hit_en   ? en_rd    :
                             hit_fctl ? fctl_rd  : 8'h00;

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            slverr_q <= pready_d && !hit_any;
            if (pready_d) begin
                prdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            en_q <= IRQ_EN_RST;
        end else if (wr_en) begin
            en_q <= PWDATA_IN[7:0] & EN_WR_MASK;
        end
    end

    // bits 7:3 are not stored and read back as zero
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            fctl_q <= FRAME_CTL_RST;
        end else if (wr_fctl) begin
            fctl_q <= PWDATA_IN[FLEC_MSB:0];
        end
    end

    remote_alarm_detect #(
        .CONSEC    (CONSEC)
    ) u_remote (
        .clk_in    (CLK_IN),
        .rstn_in   (RSTN_IN),
        .strobe_in (RX_EVENTS_IN.nfas_strobe),
        .a_bit_in  (RX_EVENTS_IN.a_bit),
        .alarm_out (rem_alarm)
    );

    // programmable loss count
    // a zero field is served as one; first good FAS clears the defect
    wire [2:0]   oof_limit = (fctl_q == 3'h0) ? 3'h1 : fctl_q;
    wire [2:0]   err_next  = (err_cnt_q == 3'h7) ? 3'h7 : err_cnt_q + 3'h1;
    wire         fas_bad   = RX_EVENTS_IN.fas_strobe && RX_EVENTS_IN.fas_err;
    wire         fas_good  = RX_EVENTS_IN.fas_strobe && !RX_EVENTS_IN.fas_err;

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            err_cnt_q <= 3'h0;
            oof_q     <= 1'b0;
        end else if (fas_bad) begin
            err_cnt_q <= err_next;
            if (err_next >= oof_limit) begin
                oof_q <= 1'b1;
            end
        end else if (fas_good) begin
            err_cnt_q <= 3'h0;
            oof_q     <= 1'b0;
        end
    end

    // previous levels give both the declare and the clear edge
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            rem_prev_q <= 1'b0;
            ais_prev_q <= 1'b0;
            cas_prev_q <= 1'b0;
            oof_prev_q <= 1'b0;
        end else begin
            rem_prev_q <= rem_alarm;
            ais_prev_q <= RX_EVENTS_IN.ais;
            cas_prev_q <= RX_EVENTS_IN.cas_mf_yel;
            oof_prev_q <= oof_q;
        end
    end

    // change events: any edge of each level, both declare and clear
    wire         rem_chg   = rem_alarm != rem_prev_q;
    wire         ais_chg   = RX_EVENTS_IN.ais != ais_prev_q;
    wire         cas_chg   = RX_EVENTS_IN.cas_mf_yel != cas_prev_q;
    wire         oof_chg   = oof_q != oof_prev_q;
    wire [7:0]   ev;

    assign ev[BIT_YEL]          = rem_chg;
    assign ev[BIT_AIS]          = ais_chg;
    assign ev[BIT_OOF]          = oof_chg;
    assign ev[BIT_LCV]          = RX_EVENTS_IN.lcv;
    // bit 4 has no event source; its enable must stay zero
    assign ev[BIT_KEEP_ZERO]    = 1'b0;
    assign ev[BIT_CAS_MF]       = cas_chg;
    assign ev[BIT_RESERVED]     = 1'b0;
    assign ev[BIT_REMOTE_STATE] = 1'b0;

    // a read clears only what it reported, so an event after capture stays
    wire [7:0]   clr = rd_stat ? prdata_q[7:0] :
                       wr_stat ? PWDATA_IN[7:0] : 8'h00;

    for (genvar i = 0; i < 8; i++) begin : g_stat
        assign status_d[i] = STAT_IMPL_MASK[i] &&
                             (ev[i] || (status_q[i] && !clr[i]));
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // masked level irq
    // bit 4 is stored but never set in status, so it cannot raise irq
    wire         irq_d = |(status_q & en_q);

    // registered so the pin comes from a flop, at one cycle of latency
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign PRDATA_OUT       = prdata_q;
    assign PREADY_OUT       = pready_q;
    assign PSLVERR_OUT      = slverr_q;
    assign REMOTE_ALARM_OUT = rem_alarm;
    assign OOF_STATE_OUT    = oof_q;
    assign IRQ_OUT          = irq_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    AST_STATE_BIT: assert property (
        pready_d && !PWRITE_IN && hit_en |=> prdata_q[7] == $past(rem_alarm))
        else $error("state bit does not show remote alarm");
    AST_RSVD_ZERO: assert property (
        $rose(pready_q) && $past(hit_en) |-> prdata_q[6] == 1'b0)
        else $error("reserved bit read as one");
    AST_CAS_CHG: assert property (
        cas_chg |=> status_q[BIT_CAS_MF])
        else $error("multiframe yellow change not latched");
    AST_LCV_IRQ: assert property (
        RX_EVENTS_IN.lcv && en_q[BIT_LCV] && !wr_en |-> ##2 IRQ_OUT)
        else $error("enabled line violation gave no interrupt");
    AST_OOF_CHG: assert property (
        oof_chg |=> status_q[BIT_OOF])
        else $error("out-of-frame change not latched");
    AST_RUR: assert property (
        rd_stat && ev == 8'h00 |=> (status_q & $past(prdata_q[7:0])) == 8'h00)
        else $error("status read did not clear reported bits");
    AST_OOF_DECL: assert property (
        fas_bad && err_next >= oof_limit |=> oof_q)
        else $error("out-of-frame not declared at count");
    AST_OOF_EARLY: assert property (
        $rose(oof_q) |-> $past(err_next >= oof_limit && fas_bad))
        else $error("out-of-frame declared early");
    AST_AIS_CHG: assert property (
        ais_chg |=> status_q[BIT_AIS])
        else $error("AIS change not latched");
    AST_YEL_CHG: assert property (
        rem_chg |=> status_q[BIT_YEL])
        else $error("remote alarm change not latched");
    AST_IRQ_GATE: assert property (
        (irq_d == 1'b0) [*2] |-> !IRQ_OUT)
        else $error("interrupt without enabled status");
    AST_EN_GATE: assert property (
        $rose(IRQ_OUT) |-> $past(|(status_q & en_q & STAT_IMPL_MASK)))
        else $error("interrupt from disabled source");

    // register write effects and state bit read-back
    AST_BIT7_RO: assert property (
        wr_en |=> !en_q[BIT_REMOTE_STATE])
        else $error("state bit stored by a write");
    AST_RSVD_EN: assert property (
        wr_en |=> !en_q[BIT_RESERVED])
        else $error("reserved enable bit stored by a write");
    AST_CAS_EN_WR: assert property (
        wr_en |=> en_q[BIT_CAS_MF] == $past(PWDATA_IN[BIT_CAS_MF]))
        else $error("multiframe yellow enable not written");
    AST_LCV_EN_WR: assert property (
        wr_en |=> en_q[BIT_LCV] == $past(PWDATA_IN[BIT_LCV]))
        else $error("line violation enable not written");
    AST_OOF_EN_WR: assert property (
        wr_en |=> en_q[BIT_OOF] == $past(PWDATA_IN[BIT_OOF]))
        else $error("out-of-frame enable not written");
    AST_FCTL_WR: assert property (
        wr_fctl |=> fctl_q == $past(PWDATA_IN[FLEC_MSB:0]))
        else $error("loss count field not written");
    AST_REM_READ: assert property (
        rd_done && hit_en |-> prdata_q[BIT_REMOTE_STATE] == $past(rem_alarm))
        else $error("state bit read back stale");

    // event capture and sticky hold
    AST_LCV_SET: assert property (
        RX_EVENTS_IN.lcv |=> status_q[BIT_LCV])
        else $error("line violation not latched");
    AST_CAS_NO_EV: assert property (
        !cas_chg && !clr[BIT_CAS_MF] |=>
        status_q[BIT_CAS_MF] == $past(status_q[BIT_CAS_MF]))
        else $error("multiframe yellow status moved without a change");
    AST_STICKY: assert property (
        |(status_q & ~clr) |=>
        (status_q & $past(status_q & ~clr)) == $past(status_q & ~clr))
        else $error("status bit lost without a clear");
    AST_STAT_UNIMPL: assert property (
        (status_q & ~STAT_IMPL_MASK) == 8'h00)
        else $error("unused status bit set");
    AST_OOF_CLR: assert property (
        fas_good |=> !oof_q)
        else $error("out-of-frame not cleared by a good FAS");
    AST_RD_NO_CLR: assert property (
        done && slverr_q && ev == 8'h00 |=> status_q == $past(status_q))
        else $error("refused access changed the status");
    AST_ALARM_STABLE: assert property (
        !RX_EVENTS_IN.nfas_strobe |=> $stable(rem_alarm))
        else $error("remote alarm moved without a frame");

    // enabled status reaches the pin
    AST_YEL_IRQ: assert property (
        status_q[BIT_YEL] && en_q[BIT_YEL] |=> IRQ_OUT)
        else $error("enabled remote alarm change gave no interrupt");
    AST_AIS_IRQ: assert property (
        status_q[BIT_AIS] && en_q[BIT_AIS] |=> IRQ_OUT)
        else $error("enabled AIS change gave no interrupt");
    AST_OOF_IRQ: assert property (
        status_q[BIT_OOF] && en_q[BIT_OOF] |=> IRQ_OUT)
        else $error("enabled out-of-frame change gave no interrupt");
    AST_CAS_IRQ: assert property (
        status_q[BIT_CAS_MF] && en_q[BIT_CAS_MF] |=> IRQ_OUT)
        else $error("enabled multiframe yellow change gave no interrupt");

    // main scenarios
    COV_IRQ: cover property ($rose(IRQ_OUT));
    COV_OOF: cover property ($rose(oof_q) ##[1:200] $fell(oof_q));
    COV_REM: cover property ($rose(rem_alarm));
    COV_ERR: cover property ($rose(slverr_q));
    COV_WR_CLR: cover property (wr_stat && |(status_q & PWDATA_IN[7:0]));
endmodule

// [tb/e1_line_model.sv]
module e1_line_model
    import e1_irq_pkg::*;
(
    // clock
    input  wire logic clk_in,
    // per-frame framer indications towards the interrupt block
    output rx_events_t ev_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial ev_out = '0;

    // kind 0 non-FAS frame with A bit v, 1 FAS frame with error flag v, 2 line code violation
    task automatic send(input logic [1:0] kind, input logic v);
        @(posedge clk_in);
        case (kind)
            2'h0: begin
                ev_out.nfas_strobe <= 1'b1;
                ev_out.a_bit       <= v;
            end
            2'h1: begin
                ev_out.fas_strobe <= 1'b1;
                ev_out.fas_err    <= v;
            end
            default: ev_out.lcv <= 1'b1;
        endcase
        @(posedge clk_in);
        ev_out.nfas_strobe <= 1'b0;
        ev_out.fas_strobe  <= 1'b0;
        ev_out.lcv         <= 1'b0;
        // qualifiers are meaningless once the strobe drops: show garbage
        ev_out.a_bit       <= ~v;
        ev_out.fas_err     <= ~v;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic levels(input logic ais, input logic cas);
        @(posedge clk_in);
        ev_out.ais        <= ais;
        ev_out.cas_mf_yel <= cas;
    endtask
endmodule

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import e1_irq_pkg::*;

    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [15:0] paddr     = 16'h0000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        remote_alarm;
    logic        oof_state;
    logic        irq;
    rx_events_t  events;
    logic [31:0] r;
    logic        e;
    int          err_total = 0;
    int          tests_run = 0;

    always #50 clk = ~clk;

    e1_line_model i_line (
        .clk_in (clk),
        .ev_out (events)
    );

    e1_alarm_error_irq_enable #(.CONSEC(REMOTE_CONSEC)) i_dut (
        .CLK_IN           (clk),
        .RSTN_IN          (rstn),
        .PSEL_IN          (psel),
        .PENABLE_IN       (penable),
        .PWRITE_IN        (pwrite),
        .PADDR_IN         (paddr),
        .PWDATA_IN        (pwdata),
        .PRDATA_OUT       (prdata),
        .PREADY_OUT       (pready),
        .PSLVERR_OUT      (pslverr),
        .RX_EVENTS_IN     (events),
        .REMOTE_ALARM_OUT (remote_alarm),
        .OOF_STATE_OUT    (oof_state),
        .IRQ_OUT          (irq)
    );

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkb(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    // the wait is left open; only the watchdog ends a hung transfer
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        // one wait state: ready is seen at the second access edge
        chk("pready wait", 32'h0000_0002, n);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [15:0] a,
                      input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, exp, r);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("ERROR watchdog expected end seen hang");
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd("enable reset", ADDR_IRQ_EN, 32'h0000_0000);
        rd("status reset", ADDR_STATUS, 32'h0000_0000);
        rd("frame ctl reset", ADDR_FRAME_CTL, 32'h0000_0003);
        $display("test reset done");
        // bit 4 always written as zero by software
        apb(1'b1, ADDR_IRQ_EN, 8'hEF);
        rd("enable readback", ADDR_IRQ_EN, 32'h0000_002F);
        chkb("irq idle", 1'b0, irq);
        $display("test enable bits done");
        i_line.send(2'h0, 1'b1);
        settle();
        chkb("remote one frame", 1'b0, remote_alarm);
        i_line.send(2'h0, 1'b1);
        settle();
        chkb("remote declared", 1'b1, remote_alarm);
        chkb("irq remote", 1'b1, irq);
        rd("enable state bit", ADDR_IRQ_EN, 32'h0000_00AF);
        rd("status remote", ADDR_STATUS, 32'h0000_0001);
        rd("status cleared", ADDR_STATUS, 32'h0000_0000);
        i_line.send(2'h0, 1'b0);
        i_line.send(2'h0, 1'b1);
        i_line.send(2'h0, 1'b0);
        settle();
        chkb("remote not consecutive", 1'b1, remote_alarm);
        i_line.send(2'h0, 1'b0);
        settle();
        chkb("remote cleared", 1'b0, remote_alarm);
        rd("status remote clear", ADDR_STATUS, 32'h0000_0001);
        $display("test remote alarm done");
        i_line.send(2'h2, 1'b1);
        settle();
        chkb("irq lcv", 1'b1, irq);
        rd("status lcv", ADDR_STATUS, 32'h0000_0008);
        settle();
        chkb("irq after read", 1'b0, irq);
        apb(1'b1, ADDR_IRQ_EN, 8'h00);
        i_line.send(2'h2, 1'b1);
        settle();
        chkb("irq masked", 1'b0, irq);
        apb(1'b1, ADDR_IRQ_EN, 8'h08);
        settle();
        chkb("irq unmasked", 1'b1, irq);
        rd("status masked lcv", ADDR_STATUS, 32'h0000_0008);
        $display("test line code done");
        apb(1'b1, ADDR_IRQ_EN, 8'h04);
        repeat (2) i_line.send(2'h1, 1'b1);
        settle();
        chkb("oof early", 1'b0, oof_state);
        i_line.send(2'h1, 1'b1);
        settle();
        chkb("oof declared", 1'b1, oof_state);
        chkb("irq oof", 1'b1, irq);
        rd("status oof set", ADDR_STATUS, 32'h0000_0004);
        i_line.send(2'h1, 1'b0);
        settle();
        chkb("oof cleared", 1'b0, oof_state);
        rd("status oof clear", ADDR_STATUS, 32'h0000_0004);
        $display("test out of frame done");
        apb(1'b1, ADDR_FRAME_CTL, 8'hF8);
        rd("frame ctl zero", ADDR_FRAME_CTL, 32'h0000_0000);
        i_line.send(2'h1, 1'b1);
        settle();
        chkb("oof at one", 1'b1, oof_state);
        apb(1'b1, ADDR_STATUS, 8'h04);
        rd("status write clear", ADDR_STATUS, 32'h0000_0000);
        i_line.send(2'h1, 1'b0);
        settle();
        chkb("oof cleared again", 1'b0, oof_state);
        chkb("irq oof clear", 1'b1, irq);
        rd("status oof again", ADDR_STATUS, 32'h0000_0004);
        $display("test frame count done");
        apb(1'b1, ADDR_IRQ_EN, 8'h22);
        i_line.levels(1'b0, 1'b1);
        settle();
        chkb("irq cas", 1'b1, irq);
        rd("status cas up", ADDR_STATUS, 32'h0000_0020);
        i_line.levels(1'b1, 1'b0);
        settle();
        rd("status cas ais", ADDR_STATUS, 32'h0000_0022);
        i_line.levels(1'b0, 1'b0);
        settle();
        rd("status ais down", ADDR_STATUS, 32'h0000_0002);
        $display("test level changes done");
        apb(1'b0, 16'h0000, 8'h00);
        chkb("unmapped slverr", 1'b1, e);
        chk("unmapped data", 32'h0000_0000, r);
        $display("test unmapped done");
        give_verdict();
    end
endmodule
